// ### shared/hsel_consts.svh
// offsets, field positions, codes and timing counts of the status block
`ifndef HSEL_CONSTS_SVH
`define HSEL_CONSTS_SVH
// ==========================================================
// register offsets (byte addresses)
`define HSEL_ADDR_CTRL 8'h00
`define HSEL_ADDR_HOLD 8'h04
`define HSEL_ADDR_LMASK 8'h08
`define HSEL_ADDR_LCODE 8'h0C
`define HSEL_ADDR_FFLAG 8'h10
`define HSEL_ADDR_FMASK 8'h14
`define HSEL_ADDR_PINS 8'h18
// ==========================================================
// field positions
`define HSEL_CTRL_ACK_BIT 0
`define HSEL_PIN_IDLE_BIT 0
`define HSEL_PIN_FAULT_BIT 1
`define HSEL_PIN_REPLY_BIT 2
// ==========================================================
// reset values and mode values
`define HSEL_RST_BYTE 8'h00
`define HSEL_HOLD_ON 8'h01
// ==========================================================
// exception codes, by event index 0..7
`define HSEL_CODE_IN_OVF 8'h08
`define HSEL_CODE_OUT_OVF 8'h09
`define HSEL_CODE_REG_WR 8'h13
`define HSEL_CODE_NO_ACK 8'h20
`define HSEL_CODE_PAY_CRC 8'h40
`define HSEL_CODE_HDR_CRC 8'h42
`define HSEL_CODE_ACK_SEQ 8'h43
`define HSEL_CODE_FRAME 8'h44
`define HSEL_IDX_IN_OVF 0
`define HSEL_IDX_OUT_OVF 1
`define HSEL_IDX_NO_ACK 3
// ==========================================================
// timing
`define HSEL_CLK_HZ 32'h0773_5940
`define HSEL_GUARD_BITS 4'hA
`endif

// ### shared/hsel_pkg.sv
// types shared by the status block modules
package hsel_pkg;
    typedef logic [7:0] hsel_byte_t;
    typedef enum logic [1:0] {
        HSEL_TX_IDLE = 2'b00,
        HSEL_TX_FILL = 2'b01,
        HSEL_TX_SEND = 2'b10,
        HSEL_TX_WAIT = 2'b11
    } hsel_tx_e;
endpackage

// ### shared/hsel_byte_if.sv
// byte stream with valid and ready between the status block modules
`timescale 1ns/1ps
`default_nettype none
interface hsel_byte_if;
    logic valid;
    logic ready;
    hsel_pkg::hsel_byte_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hw/hsel_tick.sv
// free running divider giving one enable pulse per serial bit time
`timescale 1ns/1ps
`default_nettype none
module hsel_tick #(
    parameter int DIV = 13020
) (
    input wire logic clk,
    input wire logic sys_rst,
    output logic tick
);
    localparam int CW = $clog2(DIV + 1);
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_tick = (cnt == CW'(DIV - 1));
        next_cnt = next_tick ? '0 : cnt + CW'(1);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule // hsel_tick
`default_nettype wire

// ### hw/hsel_hold_buf.sv
// flip-flop store for radio bytes waiting for the serial output
`timescale 1ns/1ps
`default_nettype none
module hsel_hold_buf #(
    parameter int DEPTH = 64
) (
    input wire logic clk,
    input wire logic sys_rst,
    hsel_byte_if.snk wr,
    hsel_byte_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int NW = $clog2(DEPTH + 1);
    hsel_pkg::hsel_byte_t mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [NW-1:0] count, next_count;
    logic push, pop, next_ready;

    always_comb begin
        push = wr.valid & wr.ready;
        pop = rd.valid & rd.ready;
        next_wp = push ? ((wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1)) : wp;
        next_rp = pop ? ((rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1)) : rp;
        next_count = count + NW'(push) - NW'(pop);
        // ready from a flop so the radio side sees a clean level
        next_ready = (next_count != NW'(DEPTH));
    end

    assign rd.valid = (count != '0);
    assign rd.data = mem[rp];

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk) begin
            if (push && wp == AW'(i)) begin
                mem[i] <= wr.data;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
            wr.ready <= 1'b0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            count <= next_count;
            wr.ready <= next_ready;
        end
    end
endmodule // hsel_hold_buf
`default_nettype wire

// ### hw/hsel_top.sv
// buffer-idle, exception and reply-source lines with wishbone registers
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hsel_consts.svh"
module hsel_top #(
    parameter int BAUD_RATE = 9600,
    parameter int BIT_CYCLES = `HSEL_CLK_HZ / BAUD_RATE,
    parameter int IN_DEPTH = 256,
    parameter int RX_DEPTH = 64
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic command_select_n,
    input wire logic uart_rx_valid,
    input wire logic engine_byte_taken,
    input wire logic engine_pkt_sent,
    input wire logic engine_ack_ok,
    input wire logic engine_retry_fail,
    input wire logic [7:0] fault_event,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    output logic resp_taken,
    input wire logic radio_valid,
    input wire logic [7:0] radio_data,
    output logic radio_ready,
    output logic uart_tx_valid,
    output logic [7:0] uart_tx_data,
    input wire logic uart_tx_ready,
    input wire logic uart_tx_idle,
    output logic tx_buffer_idle,
    output logic fault_line,
    output logic reply_flag_n
);
    localparam int PW = $clog2(IN_DEPTH + 1);
    localparam logic [3:0] GUARD_L = `HSEL_GUARD_BITS;

    // ==========================================================
    // pin synchroniser and bit tick
    logic cmd_n_meta, cmd_n_s, bit_tick;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_n_meta <= 1'b1;
            cmd_n_s <= 1'b1;
        end else begin
            cmd_n_meta <= command_select_n;
            cmd_n_s <= cmd_n_meta;
        end
    end

    hsel_tick #(.DIV(BIT_CYCLES)) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(bit_tick)
    );

    // ==========================================================
    // radio hold store
    hsel_byte_if wr_if ();
    hsel_byte_if rd_if ();
    assign wr_if.valid = radio_valid;
    assign wr_if.data = radio_data;
    assign radio_ready = wr_if.ready;

    hsel_hold_buf #(.DEPTH(RX_DEPTH)) u_hold (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(wr_if.snk),
        .rd(rd_if.src)
    );

    // ==========================================================
    // transmit path state
    hsel_pkg::hsel_tx_e tx_state, next_tx_state;
    logic [PW-1:0] pending, next_pending;
    logic ack_en, next_idle, byte_in, in_ovf, accept, drain, give_up;

    always_comb begin
        byte_in = uart_rx_valid & cmd_n_s;
        // overflowing byte is dropped, not counted
        in_ovf = byte_in & (pending == PW'(IN_DEPTH));
        accept = byte_in & ~in_ovf;
        drain = engine_byte_taken & (pending != '0);
        next_pending = pending + PW'(accept) - PW'(drain);
        give_up = (tx_state == hsel_pkg::HSEL_TX_WAIT) & engine_retry_fail;
        next_tx_state = tx_state;
        case (tx_state)
            hsel_pkg::HSEL_TX_IDLE: begin
                if (byte_in) begin
                    next_tx_state = hsel_pkg::HSEL_TX_FILL;
                end
            end
            hsel_pkg::HSEL_TX_FILL: begin
                if (next_pending == '0 && !accept) begin
                    next_tx_state = hsel_pkg::HSEL_TX_SEND;
                end
            end
            hsel_pkg::HSEL_TX_SEND: begin
                if (byte_in) begin
                    next_tx_state = hsel_pkg::HSEL_TX_FILL;
                end else if (engine_pkt_sent) begin
                    next_tx_state = ack_en ? hsel_pkg::HSEL_TX_WAIT
                                           : hsel_pkg::HSEL_TX_IDLE;
                end
            end
            hsel_pkg::HSEL_TX_WAIT: begin
                if (byte_in) begin
                    next_tx_state = hsel_pkg::HSEL_TX_FILL;
                end else if (engine_ack_ok || engine_retry_fail) begin
                    next_tx_state = hsel_pkg::HSEL_TX_IDLE;
                end
            end
            default: next_tx_state = hsel_pkg::HSEL_TX_IDLE;
        endcase
        next_idle = (next_tx_state == hsel_pkg::HSEL_TX_IDLE);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state <= hsel_pkg::HSEL_TX_IDLE;
            pending <= '0;
            tx_buffer_idle <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            pending <= next_pending;
            tx_buffer_idle <= next_idle;
        end
    end

    // ==========================================================
    // exception engine and register bus
    logic [7:0] hold_reg, lmask, lcode, flags, fmask;
    logic [7:0] next_hold, next_lmask, next_lcode, next_flags, next_fmask;
    logic [7:0] ev_all, ev_code;
    logic latch, next_latch, next_ack_en, next_fault, next_ack;
    logic [31:0] next_dat;
    logic wr_en, rd_en, out_ovf, ovf_prev, next_ovf_prev;

    function automatic logic [7:0] code_of(input logic [2:0] i);
        case (i)
            3'h0: code_of = `HSEL_CODE_IN_OVF;
            3'h1: code_of = `HSEL_CODE_OUT_OVF;
            3'h2: code_of = `HSEL_CODE_REG_WR;
            3'h3: code_of = `HSEL_CODE_NO_ACK;
            3'h4: code_of = `HSEL_CODE_PAY_CRC;
            3'h5: code_of = `HSEL_CODE_HDR_CRC;
            3'h6: code_of = `HSEL_CODE_ACK_SEQ;
            default: code_of = `HSEL_CODE_FRAME;
        endcase
    endfunction

    always_comb begin
        // one report per stalled radio byte, not per stalled cycle
        next_ovf_prev = radio_valid & ~radio_ready;
        out_ovf = next_ovf_prev & ~ovf_prev;
        ev_all = fault_event;
        ev_all[`HSEL_IDX_IN_OVF] = fault_event[`HSEL_IDX_IN_OVF] | in_ovf;
        ev_all[`HSEL_IDX_OUT_OVF] = fault_event[`HSEL_IDX_OUT_OVF] | out_ovf;
        ev_all[`HSEL_IDX_NO_ACK] = fault_event[`HSEL_IDX_NO_ACK] | give_up;
        ev_code = `HSEL_RST_BYTE;
        for (int k = 0; k < 8; k++) begin
            if (ev_all[k]) begin
                ev_code = code_of(3'(k));
            end
        end
        wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
        rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_ack_en = ack_en;
        next_hold = hold_reg;
        next_lmask = lmask;
        next_lcode = lcode;
        next_flags = flags;
        next_fmask = fmask;
        next_latch = latch;
        next_dat = '0;
        if (rd_en) begin
            case (wb_adr_i)
                `HSEL_ADDR_CTRL: next_dat[`HSEL_CTRL_ACK_BIT] = ack_en;
                `HSEL_ADDR_HOLD: next_dat[7:0] = hold_reg;
                `HSEL_ADDR_LMASK: next_dat[7:0] = lmask;
                `HSEL_ADDR_LCODE: next_dat[7:0] = lcode;
                `HSEL_ADDR_FFLAG: next_dat[7:0] = flags;
                `HSEL_ADDR_FMASK: next_dat[7:0] = fmask;
                `HSEL_ADDR_PINS: begin
                    next_dat[`HSEL_PIN_IDLE_BIT] = tx_buffer_idle;
                    next_dat[`HSEL_PIN_FAULT_BIT] = fault_line;
                    next_dat[`HSEL_PIN_REPLY_BIT] = reply_flag_n;
                end
                default: next_dat = '0;
            endcase
        end
        // only a code read clears the legacy line
        if (rd_en && wb_adr_i == `HSEL_ADDR_LCODE) begin
            next_latch = 1'b0;
        end
        if (wr_en) begin
            case (wb_adr_i)
                `HSEL_ADDR_CTRL: next_ack_en = wb_dat_i[`HSEL_CTRL_ACK_BIT];
                `HSEL_ADDR_HOLD: next_hold = wb_dat_i[7:0];
                `HSEL_ADDR_LMASK: next_lmask = wb_dat_i[7:0];
                // flags clear by writing ones
                `HSEL_ADDR_FFLAG: next_flags = flags & ~wb_dat_i[7:0];
                `HSEL_ADDR_FMASK: next_fmask = wb_dat_i[7:0];
                default: next_ack_en = ack_en;
            endcase
        end
        // events applied last so a set beats a same-cycle clear
        if (ev_all != '0) begin
            next_lcode = ev_code;
            next_flags = next_flags | ev_all;
            if ((ev_code & lmask) != '0) begin
                next_latch = 1'b1;
            end
        end
        next_fault = (next_lmask != '0) ? next_latch
                                        : |(next_flags & next_fmask);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_en <= 1'b0;
            hold_reg <= `HSEL_RST_BYTE;
            lmask <= `HSEL_RST_BYTE;
            lcode <= `HSEL_RST_BYTE;
            flags <= `HSEL_RST_BYTE;
            fmask <= `HSEL_RST_BYTE;
            latch <= 1'b0;
            fault_line <= 1'b0;
            ovf_prev <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ack_en <= next_ack_en;
            hold_reg <= next_hold;
            lmask <= next_lmask;
            lcode <= next_lcode;
            flags <= next_flags;
            fmask <= next_fmask;
            latch <= next_latch;
            fault_line <= next_fault;
            ovf_prev <= next_ovf_prev;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ==========================================================
    // serial output source selection
    logic next_out_valid, next_reply, next_resp_taken, held, can_load;
    logic [7:0] next_out_data;
    logic [3:0] guard, next_guard;
    logic load;

    always_comb begin
        held = (hold_reg == `HSEL_HOLD_ON) & ~cmd_n_s;
        can_load = ~uart_tx_valid & ~resp_taken;
        next_out_valid = uart_tx_valid & ~uart_tx_ready;
        next_out_data = uart_tx_data;
        next_reply = reply_flag_n;
        next_resp_taken = 1'b0;
        rd_if.ready = 1'b0;
        load = 1'b0;
        if (can_load) begin
            if (!reply_flag_n) begin
                if (resp_valid) begin
                    load = 1'b1;
                    next_resp_taken = 1'b1;
                    next_out_data = resp_data;
                end else if (rd_if.valid && !held && guard == GUARD_L) begin
                    next_reply = 1'b1;
                end
            end else begin
                // switch only after a byte time
                if (resp_valid) begin
                    if (guard == GUARD_L) begin
                        next_reply = 1'b0;
                    end
                end else if (rd_if.valid && !held) begin
                    load = 1'b1;
                    rd_if.ready = 1'b1;
                    next_out_data = rd_if.data;
                end
            end
        end
        if (load) begin
            next_out_valid = 1'b1;
        end
        // guard counts idle line bit times since the last byte
        next_guard = guard;
        if (load) begin
            next_guard = '0;
        end else if (bit_tick && uart_tx_idle && !uart_tx_valid
                     && guard != GUARD_L) begin
            next_guard = guard + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            uart_tx_valid <= 1'b0;
            uart_tx_data <= `HSEL_RST_BYTE;
            reply_flag_n <= 1'b1;
            resp_taken <= 1'b0;
            guard <= `HSEL_GUARD_BITS;
        end else begin
            uart_tx_valid <= next_out_valid;
            uart_tx_data <= next_out_data;
            reply_flag_n <= next_reply;
            resp_taken <= next_resp_taken;
            guard <= next_guard;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence payload_in_s;
        uart_rx_valid && cmd_n_s;
    endsequence
    sequence ack_wait_s;
        tx_state == hsel_pkg::HSEL_TX_WAIT && !engine_ack_ok
            && !engine_retry_fail && !uart_rx_valid;
    endsequence
    sequence pin_read_s;
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
            && wb_adr_i == `HSEL_ADDR_PINS;
    endsequence

    idle_drop_a: assert property (payload_in_s |=> !tx_buffer_idle)
        else $error("idle not dropped on payload byte");
    ack_hold_a: assert property (ack_wait_s |=> !tx_buffer_idle)
        else $error("idle rose before ack outcome");
    noack_done_a: assert property (
        (tx_state == hsel_pkg::HSEL_TX_SEND && engine_pkt_sent && !ack_en
            && !uart_rx_valid) |=> tx_buffer_idle)
        else $error("idle not restored after send");
    pin_mirror_a: assert property (
        pin_read_s |=> wb_ack_o
            && wb_dat_o[`HSEL_PIN_IDLE_BIT] == $past(tx_buffer_idle)
            && wb_dat_o[`HSEL_PIN_FAULT_BIT] == $past(fault_line))
        else $error("pin word mismatch");
    legacy_set_a: assert property (
        (ev_all != '0 && lmask != '0 && (ev_code & lmask) != '0)
            |=> fault_line)
        else $error("legacy fault line not set");
    scheme_tie_a: assert property (
        fault_line == ((lmask != '0) ? latch : |(flags & fmask)))
        else $error("fault line disagrees with scheme");
    code_store_a: assert property (
        (ev_all != '0) |=> lcode == $past(ev_code))
        else $error("code not stored");
    flag_set_a: assert property (
        (ev_all != '0) |=> (flags & $past(ev_all)) == $past(ev_all))
        else $error("flag bit not set");
    reply_guard_a: assert property (
        $rose(reply_flag_n) |-> $past(guard) == GUARD_L)
        else $error("reply flag rose inside guard");
    hold_rx_a: assert property (
        held |=> !(uart_tx_valid && !$past(uart_tx_valid) && reply_flag_n))
        else $error("radio byte sent while held");
endmodule // hsel_top
`default_nettype wire

// ### verification/hsel_host_model.sv
// host side serial sink taking bytes at a fixed pace
`timescale 1ns/1ps
`default_nettype none
module hsel_host_model #(
    parameter int GAP = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic uart_tx_valid,
    input wire logic [7:0] uart_tx_data,
    input wire logic reply_flag_n,
    output logic uart_tx_ready,
    output logic uart_tx_idle,
    output logic [7:0] last_byte,
    output logic last_reply_n,
    output int nbytes
);
    int cnt;
    // busy line while a byte shifts out
    assign uart_tx_idle = (cnt == 0);
    assign uart_tx_ready = uart_tx_valid && (cnt == 0);
    // byte source seen at each handshake
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            nbytes <= 0;
            last_byte <= 8'h00;
            last_reply_n <= 1'b1;
        end else if (uart_tx_ready) begin
            cnt <= GAP;
            nbytes <= nbytes + 1;
            last_byte <= uart_tx_data;
            last_reply_n <= reply_flag_n;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // hsel_host_model
`default_nettype wire

// ### verification/tb.sv
// wishbone-driven regression of the status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("Error %s exp %h got %h", nm, e, g); \
    end \
end
module tb;
    logic clk, sys_rst, cyc, stb, we, ack, csn, rsv, rv, rdy, tk;
    logic tv, tr, ti, idle, flt, rfn, lrn;
    logic [7:0] adr, rd8, ra8, td, lb;
    logic [31:0] wd, qo, q;
    logic [12:0] st;
    logic [7:0] codes [8] = '{8'h08, 8'h09, 8'h13, 8'h20,
                              8'h40, 8'h42, 8'h43, 8'h44};
    int fails = 0;
    int compares = 0;
    int nb, t;
    hsel_top #(.BIT_CYCLES(4)) i_hsel_top (.clk(clk), .sys_rst(sys_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(qo), .wb_ack_o(ack),
        .command_select_n(csn), .uart_rx_valid(st[0]),
        .engine_byte_taken(st[1]), .engine_pkt_sent(st[2]),
        .engine_ack_ok(st[3]), .engine_retry_fail(st[4]),
        .fault_event(st[12:5]), .resp_valid(rsv), .resp_data(rd8),
        .resp_taken(tk), .radio_valid(rv), .radio_data(ra8),
        .radio_ready(rdy), .uart_tx_valid(tv), .uart_tx_data(td),
        .uart_tx_ready(tr), .uart_tx_idle(ti), .tx_buffer_idle(idle),
        .fault_line(flt), .reply_flag_n(rfn));
    hsel_host_model i_hsel_host_model (.clk(clk), .sys_rst(sys_rst),
        .uart_tx_valid(tv), .uart_tx_data(td), .reply_flag_n(rfn),
        .uart_tx_ready(tr), .uart_tx_idle(ti), .last_byte(lb),
        .last_reply_n(lrn), .nbytes(nb));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ==========================================================
    // bus and strobe tasks
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = qo;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input int b);
        st <= 13'h0001 << b;
        @(posedge clk);
        st <= 13'h0000;
        @(posedge clk);
    endtask
    task automatic wait_bytes(input int k);
        t = 0;
        while (nb < k && t < 400) begin
            @(posedge clk);
            t++;
        end
    endtask
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        {cyc, stb, we, rsv, rv, adr, wd, st} = '0;
        {sys_rst, csn, rd8, ra8} = {2'b11, 8'hA5, 8'h3C};
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK("idle", 1'b1, idle)
        wb(0, 8'h18, 0);
        `CHK("pins", 32'h0000_0005, q)
        pulse(0);
        `CHK("idle", 1'b0, idle)
        pulse(1);
        pulse(2);
        `CHK("idle", 1'b1, idle)
        $display("test idle done");
        wb(1, 8'h00, 1);
        wb(1, 8'h08, 32'h0000_0020);
        pulse(0);
        pulse(1);
        pulse(2);
        `CHK("idle", 1'b0, idle)
        pulse(4);
        `CHK("idle", 1'b1, idle)
        `CHK("fault", 1'b1, flt)
        wb(0, 8'h18, 0);
        `CHK("pins", 32'h0000_0007, q)
        wb(0, 8'h0C, 0);
        `CHK("code", 32'h0000_0020, q)
        `CHK("fault", 1'b0, flt)
        wb(1, 8'h08, 32'h0000_0040);
        `CHK("fault", 1'b0, flt)
        for (int i = 0; i < 8; i++) begin
            pulse(5 + i);
            `CHK("fault", i >= 4, flt)
            wb(0, 8'h0C, 0);
            `CHK("code", {24'h0, codes[i]}, q)
        end
        pulse(5);
        pulse(6);
        wb(0, 8'h0C, 0);
        `CHK("code", 32'h0000_0009, q)
        $display("test legacy done");
        wb(1, 8'h08, 0);
        wb(0, 8'h10, 0);
        `CHK("flags", 32'h0000_00FF, q)
        wb(1, 8'h14, 32'h0000_0003);
        `CHK("fault", 1'b1, flt)
        wb(1, 8'h10, 32'h0000_0001);
        `CHK("fault", 1'b1, flt)
        wb(1, 8'h10, 32'h0000_0002);
        `CHK("fault", 1'b0, flt)
        wb(1, 8'h14, 32'h0000_0080);
        `CHK("fault", 1'b1, flt)
        $display("test flags done");
        rsv <= 1'b1;
        rv <= 1'b1;
        // one radio byte only: ready is a level, so valid must drop
        @(posedge clk);
        rv <= 1'b0;
        t = 0;
        while (tk !== 1'b1 && t < 50) begin
            @(posedge clk);
            t++;
        end
        rsv <= 1'b0;
        wait_bytes(1);
        `CHK("byte", 8'hA5, lb)
        `CHK("src", 1'b0, lrn)
        wait_bytes(2);
        `CHK("byte", 8'h3C, lb)
        `CHK("src", 1'b1, lrn)
        `CHK("gap", 1'b1, t > 36)
        $display("test reply done");
        wb(1, 8'h04, 1);
        // command mode held well past margin
        csn <= 1'b0;
        ra8 <= 8'h5A;
        repeat (4) @(posedge clk);
        rv <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (rdy !== 1'b1 && t < 50);
        rv <= 1'b0;
        repeat (60) @(posedge clk);
        `CHK("held", 2, nb)
        csn <= 1'b1;
        wait_bytes(3);
        `CHK("byte", 8'h5A, lb)
        $display("test hold done");
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule // tb
`default_nettype wire
